// ===== logic/cpu_instruction_execute_subset.sv
// execute unit for a subset of the 8-bit core instruction set, apb reached
// Functional notes
// - file operand 0..127; destination bit 0 writes accumulator, 1 writes file.
// - increment and inclusive or with accumulator update only the zero flag.
// - shift left: bit 7 to carry, zero into bit 0, carry and zero.
// - shift right: bit 0 to carry, zero into bit 7, carry and zero.
// - copy file to destination in one cycle, updating zero.
// - indirect mode 00 pre-inc, 01 pre-dec, 10 post-inc, 11 post-dec.
// - relative form uses pointer plus signed -32..31, pointer unchanged.
// - window locations have no storage; they reach the pointed location.
// - pointers span 0000h..FFFFh and wrap at both ends.
// - pointer step touches no flag; indirect load sets zero, store none.
// - load bank literal 0..15 into bank select, no flags.
// - load seven-bit literal into pc high latch, no flags.
// - load eight-bit literal into accumulator in one cycle, no flags.
// - store accumulator to file in one cycle, no flags.
// - copy accumulator into timer config register, no flags.
// - soft reset acts as full reset and clears the reset instruction flag.
// - interrupt return pops stack top to pc, sets global enable, two cycles.
// - subroutine return pops stack top into pc, two cycles, no flags.
// - return with literal loads the literal into accumulator and pc from stack top.
// - rotate left through carry, only carry changes.
// - rotate right through carry, only carry changes.
`timescale 1ns/1ps
`default_nettype none

module cpu_instruction_execute_subset (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    output logic stack_pop
);

    function automatic logic [15:0] step(input logic [15:0] p, input logic down);
        step = down ? p - 16'h0001 : p + 16'h0001;
    endfunction

    function automatic logic zero_of(input logic [7:0] v);
        zero_of = (v == 8'h00);
    endfunction

    cpu_exec_pkg::state_t state;
    cpu_exec_pkg::state_t next_state;

    logic [15:0] instr;
    logic [7:0] accum;
    logic [7:0] status;
    logic [3:0] bank_select;
    logic [6:0] pc_high_latch;
    logic [15:0] ptr0;
    logic [15:0] ptr1;
    logic [7:0] timer_config_register;
    logic [7:0] irq_control_register;
    logic [7:0] power_control_register;
    logic [14:0] stack_top;
    logic [14:0] pc;
    logic [7:0] mem_rdata;

    // instruction fields
    wire logic [4:0] op = instr[15:11];
    wire logic dest_file = instr[cpu_exec_pkg::DEST_BIT];
    wire logic [6:0] file_addr = instr[6:0];
    wire logic [7:0] literal = instr[7:0];
    wire logic ind_rel = instr[cpu_exec_pkg::REL_BIT];
    wire logic [5:0] offset = instr[5:0];
    wire logic [1:0] pointer_update_mode = instr[1:0];

    wire logic is_load_ind = (op == cpu_exec_pkg::OP_INDIRECT_LOAD);
    wire logic is_store_ind = (op == cpu_exec_pkg::OP_INDIRECT_STORE);
    wire logic is_ind = is_load_ind | is_store_ind;

    // read-modify-write file group
    wire logic is_file_op = (op >= cpu_exec_pkg::OP_INCREMENT_FILE) &&
                            (op <= cpu_exec_pkg::OP_ROTATE_RIGHT_CARRY);

    wire logic is_return = (op == cpu_exec_pkg::OP_INTERRUPT_RETURN) ||
                           (op == cpu_exec_pkg::OP_SUBROUTINE_RETURN) ||
                           (op == cpu_exec_pkg::OP_RETURN_WITH_LITERAL);

    // addresses 0 and 1 are the two indirect windows
    wire logic is_window = !is_ind && (file_addr[6:1] == 6'h00);
    wire logic ptr_sel = is_ind ? instr[cpu_exec_pkg::PTR_SEL_BIT] : file_addr[0];
    wire logic [15:0] ptr = ptr_sel ? ptr1 : ptr0;

    wire logic [15:0] rel_addr = ptr + {{10{offset[5]}}, offset};
    wire logic is_pre = (pointer_update_mode == cpu_exec_pkg::MODE_PRE_INC) ||
                        (pointer_update_mode == cpu_exec_pkg::MODE_PRE_DEC);
    wire logic step_down = pointer_update_mode[0];
    wire logic [15:0] ptr_stepped = step(ptr, step_down);

    wire logic [15:0] ind_addr = ind_rel ? rel_addr :
                                 (is_pre ? ptr_stepped : ptr);

    // the memory decodes only the low 8 pointer bits, so it repeats every 256 bytes of the pointer space
    wire logic [7:0] mem_addr = is_ind ? ind_addr[7:0] :
                                is_window ? ptr[7:0] :
                                {bank_select[0], file_addr};

    wire logic in_exe = (state == cpu_exec_pkg::S_EXE);
    wire logic carry_in = status[cpu_exec_pkg::CARRY_BIT];

    // alu for the file group
    logic [7:0] result;
    logic next_carry;
    logic upd_carry;
    logic upd_zero;

    always_comb begin
        result = mem_rdata;
        next_carry = carry_in;
        upd_carry = 1'b0;
        upd_zero = 1'b0;
        case (op)
            cpu_exec_pkg::OP_INCREMENT_FILE: begin
                result = mem_rdata + 8'h01;
                upd_zero = 1'b1;
            end
            cpu_exec_pkg::OP_OR_ACCUM_INTO_FILE: begin
                result = accum | mem_rdata;
                upd_zero = 1'b1;
            end
            cpu_exec_pkg::OP_LOGICAL_SHIFT_LEFT: begin
                result = {mem_rdata[6:0], 1'b0};
                next_carry = mem_rdata[7];
                upd_carry = 1'b1;
                upd_zero = 1'b1;
            end
            cpu_exec_pkg::OP_LOGICAL_SHIFT_RIGHT: begin
                result = {1'b0, mem_rdata[7:1]};
                next_carry = mem_rdata[0];
                upd_carry = 1'b1;
                upd_zero = 1'b1;
            end
            cpu_exec_pkg::OP_COPY_FILE: begin
                upd_zero = 1'b1;
            end
            cpu_exec_pkg::OP_ROTATE_LEFT_CARRY: begin
                result = {mem_rdata[6:0], carry_in};
                next_carry = mem_rdata[7];
                upd_carry = 1'b1;
            end
            cpu_exec_pkg::OP_ROTATE_RIGHT_CARRY: begin
                result = {carry_in, mem_rdata[7:1]};
                next_carry = mem_rdata[0];
                upd_carry = 1'b1;
            end
            cpu_exec_pkg::OP_INDIRECT_LOAD: begin
                upd_zero = 1'b1;
            end
            default: begin
                result = mem_rdata;
            end
        endcase
    end

    // memory write: file writeback, direct store or indirect store
    wire logic wr_file = is_file_op & dest_file;
    wire logic wr_accum_alu = (is_file_op & ~dest_file) | is_load_ind;
    wire logic mem_we = in_exe & (wr_file | is_store_ind |
                        (op == cpu_exec_pkg::OP_STORE_ACCUM_TO_FILE));
    wire logic [7:0] mem_wdata = is_file_op ? result : accum;

    data_ram u_ram (
        .pclk(pclk),
        .addr(mem_addr),
        .we(mem_we),
        .wdata(mem_wdata),
        .rdata(mem_rdata)
    );

    // apb decode; the slave only answers while the executor is idle
    wire logic idle = (state == cpu_exec_pkg::S_IDLE);
    wire logic apb_done = psel & penable & pready;
    wire logic apb_wr = apb_done & pwrite;
    wire logic start = apb_wr & (paddr == cpu_exec_pkg::ADDR_INSTR);
    wire logic next_pready = psel & ~pready & idle;

    wire logic hit = (paddr[1:0] == 2'b00) && (paddr <= cpu_exec_pkg::ADDR_PC);
    wire logic [31:0] rd_mux =
        (paddr == cpu_exec_pkg::ADDR_INSTR) ? {16'h0000, instr} :
        (paddr == cpu_exec_pkg::ADDR_ACCUM) ? {24'h000000, accum} :
        (paddr == cpu_exec_pkg::ADDR_STATUS) ? {24'h000000, status} :
        (paddr == cpu_exec_pkg::ADDR_BANK) ? {28'h0000000, bank_select} :
        (paddr == cpu_exec_pkg::ADDR_PCLATCH) ? {25'h0000000, pc_high_latch} :
        (paddr == cpu_exec_pkg::ADDR_PTR0) ? {16'h0000, ptr0} :
        (paddr == cpu_exec_pkg::ADDR_PTR1) ? {16'h0000, ptr1} :
        (paddr == cpu_exec_pkg::ADDR_TIMER_CFG) ? {24'h000000, timer_config_register} :
        (paddr == cpu_exec_pkg::ADDR_IRQ_CTRL) ? {24'h000000, irq_control_register} :
        (paddr == cpu_exec_pkg::ADDR_PWR_CTRL) ? {24'h000000, power_control_register} :
        (paddr == cpu_exec_pkg::ADDR_STACK_TOP) ? {17'h00000, stack_top} :
        (paddr == cpu_exec_pkg::ADDR_PC) ? {17'h00000, pc} : 32'h00000000;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else begin
            pready <= next_pready;
            pslverr <= next_pready & ~hit;
            prdata <= next_pready ? rd_mux : 32'h00000000;
        end
    end

    // sequencer: decode cycle reads memory, execute cycle commits
    always_comb begin
        case (state)
            cpu_exec_pkg::S_IDLE: next_state = start ? cpu_exec_pkg::S_DEC : state;
            cpu_exec_pkg::S_DEC: next_state = cpu_exec_pkg::S_EXE;
            cpu_exec_pkg::S_EXE: next_state = is_return ? cpu_exec_pkg::S_RET :
                                              cpu_exec_pkg::S_IDLE;
            cpu_exec_pkg::S_RET: next_state = cpu_exec_pkg::S_IDLE;
            default: next_state = cpu_exec_pkg::S_IDLE;
        endcase
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= cpu_exec_pkg::S_IDLE;
            instr <= 16'h0000;
            stack_pop <= 1'b0;
        end else begin
            state <= next_state;
            stack_pop <= in_exe & is_return;
            if (start) begin
                instr <= pwdata[15:0];
            end
        end
    end

    wire logic soft_reset = in_exe & (op == cpu_exec_pkg::OP_SOFT_RESET);

    // pointer after an indirect move: post forms step now, pre forms keep
    // the already stepped value, relative form leaves it alone
    wire logic ptr_upd = in_exe & is_ind & ~ind_rel;

    // architectural state; apb writes only land while idle, so they never
    // collide with an executing instruction
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            accum <= 8'h00;
            status <= cpu_exec_pkg::STATUS_RST;
            bank_select <= 4'h0;
            pc_high_latch <= 7'h00;
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
            timer_config_register <= cpu_exec_pkg::TIMER_CFG_RST;
            irq_control_register <= cpu_exec_pkg::IRQ_CTRL_RST;
            power_control_register <= cpu_exec_pkg::PWR_CTRL_RST;
            stack_top <= 15'h0000;
            pc <= 15'h0000;
        end else if (soft_reset) begin
            accum <= 8'h00;
            status <= cpu_exec_pkg::STATUS_RST;
            bank_select <= 4'h0;
            pc_high_latch <= 7'h00;
            ptr0 <= 16'h0000;
            ptr1 <= 16'h0000;
            timer_config_register <= cpu_exec_pkg::TIMER_CFG_RST;
            irq_control_register <= cpu_exec_pkg::IRQ_CTRL_RST;
            power_control_register <= cpu_exec_pkg::PWR_CTRL_RST &
                                      ~(8'h01 << cpu_exec_pkg::RI_BIT);
            stack_top <= 15'h0000;
            pc <= 15'h0000;
        end else begin
            if (apb_wr) begin
                case (paddr)
                    cpu_exec_pkg::ADDR_ACCUM: accum <= pwdata[7:0];
                    cpu_exec_pkg::ADDR_STATUS: status <= pwdata[7:0];
                    cpu_exec_pkg::ADDR_BANK: bank_select <= pwdata[3:0];
                    cpu_exec_pkg::ADDR_PCLATCH: pc_high_latch <= pwdata[6:0];
                    cpu_exec_pkg::ADDR_PTR0: ptr0 <= pwdata[15:0];
                    cpu_exec_pkg::ADDR_PTR1: ptr1 <= pwdata[15:0];
                    cpu_exec_pkg::ADDR_TIMER_CFG: timer_config_register <= pwdata[7:0];
                    cpu_exec_pkg::ADDR_IRQ_CTRL: irq_control_register <= pwdata[7:0];
                    cpu_exec_pkg::ADDR_PWR_CTRL: power_control_register <= pwdata[7:0];
                    cpu_exec_pkg::ADDR_STACK_TOP: stack_top <= pwdata[14:0];
                    cpu_exec_pkg::ADDR_PC: pc <= pwdata[14:0];
                    default: accum <= accum;
                endcase
            end
            if (in_exe) begin
                if (wr_accum_alu) begin
                    accum <= result;
                end
                if (upd_carry) begin
                    status[cpu_exec_pkg::CARRY_BIT] <= next_carry;
                end
                if (upd_zero) begin
                    status[cpu_exec_pkg::ZERO_BIT] <= zero_of(result);
                end
                if (ptr_upd && !ptr_sel) begin
                    ptr0 <= ptr_stepped;
                end
                if (ptr_upd && ptr_sel) begin
                    ptr1 <= ptr_stepped;
                end
                case (op)
                    cpu_exec_pkg::OP_LOAD_BANK_LITERAL:
                        bank_select <= literal[3:0];
                    cpu_exec_pkg::OP_LOAD_PAGE_LATCH:
                        pc_high_latch <= literal[6:0];
                    cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL:
                        accum <= literal;
                    cpu_exec_pkg::OP_LOAD_TIMER_CONFIG:
                        timer_config_register <= accum;
                    cpu_exec_pkg::OP_INTERRUPT_RETURN: begin
                        pc <= stack_top;
                        irq_control_register[cpu_exec_pkg::GIE_BIT] <= 1'b1;
                    end
                    cpu_exec_pkg::OP_SUBROUTINE_RETURN:
                        pc <= stack_top;
                    cpu_exec_pkg::OP_RETURN_WITH_LITERAL: begin
                        accum <= literal;
                        pc <= stack_top;
                    end
                    default: pc <= pc;
                endcase
            end
        end
    end

endmodule // cpu_instruction_execute_subset

`default_nettype wire

// ===== logic/cpu_exec_pkg.sv
// constants and types shared by the execute unit
package cpu_exec_pkg;

    // register byte addresses on the apb side
    localparam logic [7:0] ADDR_INSTR = 8'h00;
    localparam logic [7:0] ADDR_ACCUM = 8'h04;
    localparam logic [7:0] ADDR_STATUS = 8'h08;
    localparam logic [7:0] ADDR_BANK = 8'h0C;
    localparam logic [7:0] ADDR_PCLATCH = 8'h10;
    localparam logic [7:0] ADDR_PTR0 = 8'h14;
    localparam logic [7:0] ADDR_PTR1 = 8'h18;
    localparam logic [7:0] ADDR_TIMER_CFG = 8'h1C;
    localparam logic [7:0] ADDR_IRQ_CTRL = 8'h20;
    localparam logic [7:0] ADDR_PWR_CTRL = 8'h24;
    localparam logic [7:0] ADDR_STACK_TOP = 8'h28;
    localparam logic [7:0] ADDR_PC = 8'h2C;

    // field positions
    localparam int CARRY_BIT = 0;
    localparam int ZERO_BIT = 2;
    localparam int GIE_BIT = 7;
    localparam int RI_BIT = 2;
    localparam int DEST_BIT = 7;
    localparam int REL_BIT = 7;
    localparam int PTR_SEL_BIT = 6;

    // reset values
    localparam logic [7:0] STATUS_RST = 8'h00;
    localparam logic [7:0] IRQ_CTRL_RST = 8'h00;
    localparam logic [7:0] PWR_CTRL_RST = 8'h04;
    localparam logic [7:0] TIMER_CFG_RST = 8'hFF;

    // opcodes in instr[15:11]
    localparam logic [4:0] OP_NOP = 5'h00;
    localparam logic [4:0] OP_INCREMENT_FILE = 5'h01;
    localparam logic [4:0] OP_OR_ACCUM_INTO_FILE = 5'h02;
    localparam logic [4:0] OP_LOGICAL_SHIFT_LEFT = 5'h03;
    localparam logic [4:0] OP_LOGICAL_SHIFT_RIGHT = 5'h04;
    localparam logic [4:0] OP_COPY_FILE = 5'h05;
    localparam logic [4:0] OP_ROTATE_LEFT_CARRY = 5'h06;
    localparam logic [4:0] OP_ROTATE_RIGHT_CARRY = 5'h07;
    localparam logic [4:0] OP_STORE_ACCUM_TO_FILE = 5'h08;
    localparam logic [4:0] OP_INDIRECT_LOAD = 5'h09;
    localparam logic [4:0] OP_INDIRECT_STORE = 5'h0A;
    localparam logic [4:0] OP_LOAD_BANK_LITERAL = 5'h0B;
    localparam logic [4:0] OP_LOAD_PAGE_LATCH = 5'h0C;
    localparam logic [4:0] OP_LOAD_ACCUM_LITERAL = 5'h0D;
    localparam logic [4:0] OP_LOAD_TIMER_CONFIG = 5'h0E;
    localparam logic [4:0] OP_SOFT_RESET = 5'h0F;
    localparam logic [4:0] OP_INTERRUPT_RETURN = 5'h10;
    localparam logic [4:0] OP_SUBROUTINE_RETURN = 5'h11;
    localparam logic [4:0] OP_RETURN_WITH_LITERAL = 5'h12;

    // pointer_update_mode codes
    localparam logic [1:0] MODE_PRE_INC = 2'h0;
    localparam logic [1:0] MODE_PRE_DEC = 2'h1;

    typedef enum logic [3:0] {
        S_IDLE = 4'b0001,
        S_DEC = 4'b0010,
        S_EXE = 4'b0100,
        S_RET = 4'b1000
    } state_t;

endpackage

// ===== logic/data_ram.sv
// byte-wide data memory with registered read data
`timescale 1ns/1ps
`default_nettype none

module data_ram (
    input wire logic pclk,
    input wire logic [7:0] addr,
    input wire logic we,
    input wire logic [7:0] wdata,
    output logic [7:0] rdata
);

    logic [7:0] mem [0:255];

    always_ff @(posedge pclk) begin
        if (we) begin
            mem[addr] <= wdata;
        end
        rdata <= mem[addr];
    end

endmodule // data_ram

`default_nettype wire

// ===== sim/cpu_exec_props.sv
// concurrent checks on the apb side of the execute unit
`timescale 1ns/1ps
`default_nettype none

module cpu_exec_props (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [7:0] paddr,
    input wire logic [31:0] pwdata,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic stack_pop
);
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    logic done;
    logic instr_req;
    logic ret_req;
    assign done = psel && penable && pready;
    assign instr_req = done && pwrite && paddr == cpu_exec_pkg::ADDR_INSTR;
    assign ret_req = instr_req && pwdata[15:11] inside {cpu_exec_pkg::OP_INTERRUPT_RETURN,
        cpu_exec_pkg::OP_SUBROUTINE_RETURN, cpu_exec_pkg::OP_RETURN_WITH_LITERAL};

    property p_ready_pulse;
        pready |=> !pready;
    endproperty
    a_ready_pulse: assert property (p_ready_pulse) else $error("ready held two cycles");
    property p_ready_access;
        pready |-> psel && penable;
    endproperty
    a_ready_access: assert property (p_ready_access) else $error("ready outside access");
    property p_idle_quiet;
        !pready |-> prdata == 32'h0 && !pslverr;
    endproperty
    a_idle_quiet: assert property (p_idle_quiet) else $error("data or error without ready");
    property p_unmapped;
        done && (paddr[1:0] != 2'b00 || paddr > 8'h2C) |-> pslverr && prdata == 32'h0;
    endproperty
    a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
    property p_mapped;
        done && paddr[1:0] == 2'b00 && paddr <= 8'h2C |-> !pslverr;
    endproperty
    a_mapped: assert property (p_mapped) else $error("mapped access refused");
    property p_exec_busy;
        instr_req |=> !pready [*2];
    endproperty
    a_exec_busy: assert property (p_exec_busy) else $error("ready during execution");
    property p_ret_busy;
        ret_req |=> !pready [*3];
    endproperty
    a_ret_busy: assert property (p_ret_busy) else $error("return too short");
    property p_pop_after_ret;
        ret_req |-> ##3 stack_pop;
    endproperty
    a_pop_after_ret: assert property (p_pop_after_ret) else $error("no pop");
    property p_pop_cause;
        stack_pop |-> $past(ret_req, 3) && !$past(stack_pop);
    endproperty
    a_pop_cause: assert property (p_pop_cause) else $error("pop without return");
endmodule // cpu_exec_props

`default_nettype wire

// ===== sim/cpu_instruction_execute_subset_bench.sv
// self-checking bench for the execute unit, apb driven
`timescale 1ns/1ps
`default_nettype none

module cpu_instruction_execute_subset_bench;
    typedef struct {logic [31:0] d; logic chk; logic err;} note_t;
    logic pclk = 1'b0;
    logic presetn = 1'b0;
    logic psel = 1'b0;
    logic penable = 1'b0;
    logic pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h0;
    logic [31:0] prdata;
    logic pready;
    logic pslverr;
    logic stack_pop;
    note_t notes[$];
    note_t cur;
    int miscompares = 0;
    int tests_run = 0;
    logic [4:0] alu_ops [6] = '{cpu_exec_pkg::OP_INCREMENT_FILE,
        cpu_exec_pkg::OP_OR_ACCUM_INTO_FILE, cpu_exec_pkg::OP_LOGICAL_SHIFT_LEFT,
        cpu_exec_pkg::OP_LOGICAL_SHIFT_RIGHT, cpu_exec_pkg::OP_ROTATE_LEFT_CARRY,
        cpu_exec_pkg::OP_ROTATE_RIGHT_CARRY};
    logic [4:0] ret_ops [3] = '{cpu_exec_pkg::OP_INTERRUPT_RETURN,
        cpu_exec_pkg::OP_SUBROUTINE_RETURN, cpu_exec_pkg::OP_RETURN_WITH_LITERAL};

    always #4 pclk = ~pclk;

    cpu_instruction_execute_subset cpu_instruction_execute_subset_inst (
        .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .stack_pop(stack_pop));

    task automatic final_report();
        if (miscompares == 0 && tests_run > 0) begin
            $display("Testbench passed");
        end else begin
            $display("Testbench failed");
        end
        $finish;
    endtask

    task automatic cmp_data(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t read %h expected %h", $time, got, exp);
        end
    endtask

    task automatic cmp_err(input logic got, input logic exp);
        tests_run++;
        if (got !== exp) begin
            miscompares++;
            $display("MISMATCH %0t slave error %b expected %b", $time, got, exp);
        end
    endtask

    // completed transfers are matched against the driver's notes in order
    always @(posedge pclk) begin
        if (presetn && psel && penable && pready === 1'b1) begin
            cur = notes.pop_front();
            cmp_err(pslverr, cur.err);
            if (cur.chk) begin
                cmp_data(prdata, cur.d);
            end
        end
    end

    // an idle cycle before each setup keeps one assignment per signal per step
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
        input logic [31:0] e, input logic c, input logic er);
        int n;
        notes.push_back('{e, c, er});
        @(posedge pclk);
        psel <= 1'b1;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'b1;
        n = 0;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'b1 && n < 100);
        if (n >= 100) begin
            miscompares++;
            $display("MISMATCH %0t no ready", $time);
            final_report();
        end else begin
            psel <= 1'b0;
            penable <= 1'b0;
        end
    endtask

    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        xfer(1'b1, a, d, 32'h0, 1'b0, 1'b0);
    endtask

    task automatic rd(input logic [7:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0, e, 1'b1, 1'b0);
    endtask

    task automatic ex(input logic [4:0] op, input logic [10:0] lo);
        wr(cpu_exec_pkg::ADDR_INSTR, {16'h0000, op, lo});
    endtask

    function automatic logic [31:0] st(input logic c, input logic z);
        return {29'h0, z, 1'b0, c};
    endfunction

    initial begin
        int r;
        int i;
        logic [7:0] a, w, v, res;
        logic c, z, d, cn, zn;
        logic [15:0] p, np, ea, q;
        logic [5:0] k;
        void'($urandom(42));
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        rd(cpu_exec_pkg::ADDR_PWR_CTRL, 32'h04);
        rd(cpu_exec_pkg::ADDR_TIMER_CFG, 32'hFF);
        wr(cpu_exec_pkg::ADDR_STATUS, 32'h5);
        v = 8'($urandom);
        ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, {3'b0, v});
        rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, v});
        ex(cpu_exec_pkg::OP_LOAD_BANK_LITERAL, 11'h00F);
        rd(cpu_exec_pkg::ADDR_BANK, 32'hF);
        ex(cpu_exec_pkg::OP_LOAD_PAGE_LATCH, 11'h07F);
        rd(cpu_exec_pkg::ADDR_PCLATCH, 32'h7F);
        ex(cpu_exec_pkg::OP_LOAD_TIMER_CONFIG, 11'h000);
        rd(cpu_exec_pkg::ADDR_TIMER_CFG, {24'h0, v});
        ex(cpu_exec_pkg::OP_STORE_ACCUM_TO_FILE, 11'h020);
        ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, 11'h000);
        rd(cpu_exec_pkg::ADDR_STATUS, 32'h5);
        ex(cpu_exec_pkg::OP_COPY_FILE, 11'h020);
        rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, v});
        rd(cpu_exec_pkg::ADDR_STATUS, st(1'b1, v == 8'h00));
        // first round uses edge values: increment wraps, shift left clears to zero
        for (r = 0; r < 3; r++) begin
            for (i = 0; i < 6; i++) begin
                a = (r == 0) ? ((i == 0) ? 8'hFF : 8'h80) : 8'($urandom);
                w = (r == 0) ? 8'h00 : 8'($urandom);
                c = 1'($urandom);
                z = 1'($urandom);
                d = (r == 0) ? 1'b1 : 1'($urandom);
                ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, {3'b0, a});
                ex(cpu_exec_pkg::OP_STORE_ACCUM_TO_FILE, 11'h030);
                ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, {3'b0, w});
                wr(cpu_exec_pkg::ADDR_STATUS, st(c, z));
                ex(alu_ops[i], {3'b0, d, 7'h30});
                res = (i == 0) ? a + 8'h01 : (i == 1) ? (a | w) : (i == 2) ? {a[6:0], 1'b0} :
                    (i == 3) ? {1'b0, a[7:1]} : (i == 4) ? {a[6:0], c} : {c, a[7:1]};
                cn = (i < 2) ? c : (i == 2 || i == 4) ? a[7] : a[0];
                zn = (i < 4) ? (res == 8'h00) : z;
                rd(cpu_exec_pkg::ADDR_STATUS, st(cn, zn));
                rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, d ? w : res});
                ex(cpu_exec_pkg::OP_COPY_FILE, 11'h030);
                rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, d ? res : a});
            end
        end
        // pointer bounds chosen so both pre modes wrap
        for (i = 0; i < 4; i++) begin
            p = (i == 0) ? 16'hFFFF : (i == 1) ? 16'h0000 : 16'h1250;
            np = i[0] ? p - 16'h0001 : p + 16'h0001;
            ea = (i < 2) ? np : p;
            v = 8'($urandom);
            c = 1'($urandom);
            z = 1'($urandom);
            wr(cpu_exec_pkg::ADDR_PTR0, {16'h0, p});
            ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, {3'b0, v});
            wr(cpu_exec_pkg::ADDR_STATUS, st(c, z));
            ex(cpu_exec_pkg::OP_INDIRECT_STORE, {9'h000, i[1:0]});
            rd(cpu_exec_pkg::ADDR_PTR0, {16'h0, np});
            rd(cpu_exec_pkg::ADDR_STATUS, st(c, z));
            k = 6'($urandom);
            q = ea - {{10{k[5]}}, k};
            wr(cpu_exec_pkg::ADDR_PTR1, {16'h0, q});
            ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, {3'b0, ~v});
            ex(cpu_exec_pkg::OP_INDIRECT_LOAD, {3'b0, 2'b11, k});
            rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, v});
            rd(cpu_exec_pkg::ADDR_PTR1, {16'h0, q});
            rd(cpu_exec_pkg::ADDR_STATUS, st(c, v == 8'h00));
            ex(cpu_exec_pkg::OP_LOAD_BANK_LITERAL, {10'h0, ea[7]});
            ex(cpu_exec_pkg::OP_COPY_FILE, {4'b0, ea[6:0]});
            rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, v});
        end
        for (i = 0; i < 3; i++) begin
            q = 16'($urandom) & 16'h7FFF;
            v = 8'($urandom);
            w = 8'($urandom);
            wr(cpu_exec_pkg::ADDR_STACK_TOP, {16'h0, q});
            wr(cpu_exec_pkg::ADDR_IRQ_CTRL, 32'h0);
            ex(cpu_exec_pkg::OP_LOAD_ACCUM_LITERAL, {3'b0, v});
            ex(ret_ops[i], {3'b0, w});
            rd(cpu_exec_pkg::ADDR_PC, {16'h0, q});
            rd(cpu_exec_pkg::ADDR_IRQ_CTRL, (i == 0) ? 32'h80 : 32'h0);
            rd(cpu_exec_pkg::ADDR_ACCUM, {24'h0, (i == 2) ? w : v});
        end
        wr(cpu_exec_pkg::ADDR_IRQ_CTRL, 32'h80);
        wr(cpu_exec_pkg::ADDR_STATUS, 32'h5);
        ex(cpu_exec_pkg::OP_SOFT_RESET, 11'h000);
        rd(cpu_exec_pkg::ADDR_PWR_CTRL, 32'h0);
        rd(cpu_exec_pkg::ADDR_TIMER_CFG, 32'hFF);
        rd(cpu_exec_pkg::ADDR_IRQ_CTRL, 32'h0);
        rd(cpu_exec_pkg::ADDR_STATUS, 32'h0);
        xfer(1'b0, 8'h30, 32'h0, 32'h0, 1'b1, 1'b1);
        xfer(1'b1, 8'h05, 32'hFF, 32'h0, 1'b0, 1'b1);
        final_report();
    end
endmodule // cpu_instruction_execute_subset_bench

bind cpu_instruction_execute_subset cpu_exec_props cpu_exec_props_inst (
    .pclk(pclk), .presetn(presetn), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .stack_pop(stack_pop));

`default_nettype wire
